// *** rms_pkg.sv ***
package rms_pkg;

  // ********************************************************
  // operating modes
  // ********************************************************
  typedef enum logic [1:0] {
    ModeUser,
    ModeSelfCheck,
    ModeBootstrap
  } rms_mode_t;

  // ********************************************************
  // address windows
  // ********************************************************
  localparam logic [15:0] SELF_CHECK_START = 16'h3F00;
  localparam logic [15:0] SELF_CHECK_END = 16'h3FDF;
  localparam logic [15:0] USER_MEM_START = 16'h2000;
  localparam logic [15:0] USER_MEM_END = 16'h3EFF;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int STRAP_CAPTURE_CYCLES = 2;
  localparam int WDOG_TIMEOUT_CYCLES = 114688;
  localparam int WDOG_PULSE_CYCLES = 2;
  localparam int REPORT_STEP_CYCLES = 16;

  // ********************************************************
  // report patterns (1 = led off) on bits hi, mid, lo
  // ********************************************************
  localparam logic [2:0] REPORT_IO_FAULT = 3'h6;
  localparam logic [2:0] REPORT_RAM_FAULT = 3'h5;
  localparam logic [2:0] REPORT_ROM_FAULT = 3'h4;
  localparam logic [2:0] REPORT_IRQ_FAULT = 3'h3;
  localparam logic [2:0] REPORT_ALL_ON = 3'h0;
  localparam logic [2:0] REPORT_ALL_OFF = 3'h7;

  // fault results from the self-check routine, one bit per unit
  typedef struct packed {
    logic ioFault;
    logic ramFault;
    logic romFault;
    logic irqFault;
  } rms_faults_t;

  // led outputs on port b
  typedef struct packed {
    logic ledHi;
    logic ledMid;
    logic ledLo;
  } rms_leds_t;

endpackage

// *** rms_watchdog.sv ***
`timescale 1ns/100ps
`default_nettype none
module rms_watchdog #(
  parameter int TIMEOUT = rms_pkg::WDOG_TIMEOUT_CYCLES,
  parameter int PULSE = rms_pkg::WDOG_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // service and reset request
  input wire logic service,
  output logic wdogReset
);
  import rms_pkg::*;

  logic [19:0] count_q;
  logic [3:0] pulse_q;

  // always counting; no enable exists, service or expiry restarts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 20'h00000;
    end else if (service || pulse_q != 4'h0) begin
      count_q <= 20'h00000;
    end else if (count_q == 20'(TIMEOUT - 1)) begin
      count_q <= 20'h00000;
    end else begin
      count_q <= count_q + 20'h00001;
    end
  end

  // reset pulse stretched so the whole part sees it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_q <= 4'h0;
    end else if (!service && pulse_q == 4'h0 && count_q == 20'(TIMEOUT - 1)) begin
      pulse_q <= 4'(PULSE);
    end else if (pulse_q != 4'h0) begin
      pulse_q <= pulse_q - 4'h1;
    end
  end

  assign wdogReset = (pulse_q != 4'h0);
endmodule
`default_nettype wire

// *** rms_mode_select.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - watchdog always runs, cannot be disabled, resets the part on expiry
// - normal interrupt level at reset release selects user mode
// - strap level is captured in the first two cycles, then ordinary pin
// - self-check mode starts execution at the masked test routine
// - self-check repeats forever, leds toggle while part is good and passes come more than STEP_CYCLES cycles apart
// - leds on bits hi, mid, lo report pass by toggling or fault codes
// - elevated interrupt and strap high select bootstrap on programmable variant
// - bootstrap may program user memory from 2000 to 3EFF
module rms_mode_select #(
  parameter bit PROGRAMMABLE = 1'b0,
  parameter int WDOG_TIMEOUT = rms_pkg::WDOG_TIMEOUT_CYCLES,
  parameter int STEP_CYCLES = rms_pkg::REPORT_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // reset-time pins
  input wire logic irqElevated,
  input wire logic modeStrapPin,
  // watchdog service and whole-chip reset
  input wire logic wdogService,
  output logic chipReset,
  // mode and processor start
  output rms_pkg::rms_mode_t mode,
  output logic modeValid,
  output logic [15:0] startVector,
  // self-check results from the routine
  input wire logic selfCheckPassDone,
  input wire rms_pkg::rms_faults_t selfCheckFaults,
  output logic selfCheckRestart,
  // bootstrap write window check
  input wire logic [15:0] progAddr,
  output logic progAllowed,
  // port b report leds (1 = led off)
  output rms_pkg::rms_leds_t reportLeds,
  output logic reportLedsOe
);
  import rms_pkg::*;

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [2:0] irqSync_q;
  logic [2:0] strapSync_q;
  logic irqStable_q;
  logic strapStable_q;
  logic wdogReset;

  // three stages; a change counts once stages two and three agree
  // the chain has no reset on purpose: it keeps sampling the pins while rst
  // is high, so the stages hold settled levels by the time rst falls and
  // the mode can be taken inside the two cycles the board holds its levels
  // limitation: the board must set its levels three edges before release
  always_ff @(posedge clk) begin
    irqSync_q <= {irqSync_q[1:0], irqElevated};
    strapSync_q <= {strapSync_q[1:0], modeStrapPin};
  end

  // filtered levels follow only when stages two and three agree
  // the filter is reset, so a level is never taken as elevated during reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStable_q <= 1'b0;
      strapStable_q <= 1'b0;
    end else begin
      if (irqSync_q[1] == irqSync_q[2]) begin
        irqStable_q <= irqSync_q[2];
      end
      if (strapSync_q[1] == strapSync_q[2]) begin
        strapStable_q <= strapSync_q[2];
      end
    end
  end

  // ********************************************************
  // mode capture window
  // ********************************************************
  // the filtered levels are valid at the first edge after release, and the
  // decision falls on the second edge, the last one the board still covers;
  // waiting longer would read pins that have gone back to ordinary use
  localparam int CAPTURE_AT = STRAP_CAPTURE_CYCLES - 1;
  logic [3:0] capCount_q;
  logic captured_q;
  rms_mode_t mode_q;

  // counts cycles from reset release up to the capture point
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capCount_q <= 4'h0;
    end else if (!captured_q) begin
      capCount_q <= capCount_q + 4'h1;
    end
  end

  // decide once per reset, then ignore the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= ModeUser;
      captured_q <= 1'b0;
    end else if (!captured_q && capCount_q == 4'(CAPTURE_AT)) begin
      captured_q <= 1'b1;
      // the strap only matters with the elevated level; the masked variant
      // takes an elevated level as self-check whatever the strap reads
      if (!irqStable_q) begin
        mode_q <= ModeUser;
      end else if (PROGRAMMABLE && strapStable_q) begin
        mode_q <= ModeBootstrap;
      end else begin
        mode_q <= ModeSelfCheck;
      end
    end
  end

  // mode and its valid flag stand until the next reset
  assign mode = mode_q;
  assign modeValid = captured_q;

  // ********************************************************
  // processor start and bootstrap window
  // ********************************************************
  // self-check branches to the masked routine
  // user and bootstrap keep the normal vector path, shown here as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startVector <= 16'h0000;
    end else if (mode_q == ModeSelfCheck) begin
      startVector <= SELF_CHECK_START;
    end else begin
      startVector <= 16'h0000;
    end
  end

  // inclusive address window test
  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // only the user region may be written, never the self-check area
  // the area above the user region stays read-only in every mode
  assign progAllowed = captured_q && (mode_q == ModeBootstrap)
                       && inRange(progAddr, USER_MEM_START, USER_MEM_END);

  // ********************************************************
  // self-check reporting
  // ********************************************************
  logic [2:0] report_q;
  logic faultSeen_q;
  logic [7:0] step_q;
  logic selfCheck;

  // gated by the latch so reset-time values never start the reporting
  assign selfCheck = captured_q && (mode_q == ModeSelfCheck);

  // a failing pass freezes the code; a clean pass restarts, and toggles if step_q has reached STEP_CYCLES
  // the first failing unit in the order io, ram, rom, irq names the code;
  // later passes are ignored so the code stays readable on the leds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      report_q <= REPORT_ALL_OFF;
      faultSeen_q <= 1'b0;
      step_q <= 8'h00;
      selfCheckRestart <= 1'b0;
    end else begin
      selfCheckRestart <= 1'b0;
      if (selfCheck && !faultSeen_q && selfCheckPassDone) begin
        step_q <= 8'h00;
        if (selfCheckFaults.ioFault) begin
          report_q <= REPORT_IO_FAULT;
          faultSeen_q <= 1'b1;
        end else if (selfCheckFaults.ramFault) begin
          report_q <= REPORT_RAM_FAULT;
          faultSeen_q <= 1'b1;
        end else if (selfCheckFaults.romFault) begin
          report_q <= REPORT_ROM_FAULT;
          faultSeen_q <= 1'b1;
        end else if (selfCheckFaults.irqFault) begin
          report_q <= REPORT_IRQ_FAULT;
          faultSeen_q <= 1'b1;
        end else begin
          selfCheckRestart <= 1'b1;
          // toggle only after a minimum gap since the last pass, so a loop
          // faster than the gap clears step_q every pass and never blinks
          if (step_q == 8'(STEP_CYCLES)) begin
            report_q <= ~report_q;
          end
        end
      end else if (selfCheck && !faultSeen_q && step_q != 8'(STEP_CYCLES)) begin
        // saturates, so a long pass never wraps the gap back to zero
        step_q <= step_q + 8'h01;
      end
    end
  end

  // the pins are driven only in self-check; otherwise they stay ordinary
  assign reportLeds = report_q;
  assign reportLedsOe = selfCheck;

  // ********************************************************
  // supervisory watchdog
  // ********************************************************
  // reset of the chip is the watchdog pulse; external reset is rst itself
  // there is no enable input at all, so software cannot turn it off; a
  // watchdog reset leaves the latched mode alone, the system acts on it
  rms_watchdog #(
    .TIMEOUT(WDOG_TIMEOUT),
    .PULSE(WDOG_PULSE_CYCLES)
  ) uWatchdog (
    .clk(clk),
    .rst(rst),
    .service(wdogService),
    .wdogReset(wdogReset)
  );

  assign chipReset = wdogReset;
endmodule
`default_nettype wire

// *** rms_mode_select_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module rms_mode_select_asserts #(
  parameter bit PROGRAMMABLE = 1'b0,
  parameter int WDOG_TIMEOUT = 64,
  parameter int STEP_CYCLES = 16
) (
  // clock, reset and pins
  input wire logic clk, input wire logic rst,
  input wire logic irqElevated, input wire logic modeStrapPin,
  // self-check results and bootstrap address
  input wire logic selfCheckPassDone, input wire rms_pkg::rms_faults_t selfCheckFaults,
  input wire logic [15:0] progAddr,
  // design outputs
  input wire logic chipReset, input wire rms_pkg::rms_mode_t mode, input wire logic modeValid,
  input wire logic [15:0] startVector, input wire logic selfCheckRestart,
  input wire logic progAllowed, input wire rms_pkg::rms_leds_t reportLeds,
  input wire logic reportLedsOe
);
  import rms_pkg::*;
  logic faultSeen_q;
  // a latched fault freezes the report, so later passes must not count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultSeen_q <= 1'b0;
    end else if (selfCheckPassDone && mode == ModeSelfCheck && selfCheckFaults != 4'h0) begin
      faultSeen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_wdogPulse; $rose(chipReset) |=> chipReset ##1 !chipReset; endproperty
  a_wdogPulse: assert property (p_wdogPulse) else $error("reset pulse width");
  // pins may leave their levels right after capture, so look one edge back
  property p_user; $rose(modeValid) && !$past(irqElevated) |-> mode == ModeUser; endproperty
  a_user: assert property (p_user) else $error("user mode not taken");
  property p_elev; $rose(modeValid) && $past(irqElevated) |->
    mode == ((PROGRAMMABLE && $past(modeStrapPin)) ? ModeBootstrap : ModeSelfCheck);
  endproperty
  a_elev: assert property (p_elev) else $error("elevated mode wrong");
  property p_hold; modeValid && $past(modeValid) |-> $stable(mode); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_vec; $rose(modeValid) |=>
    startVector == (mode == ModeSelfCheck ? SELF_CHECK_START : 16'h0000); endproperty
  a_vec: assert property (p_vec) else $error("start vector wrong");
  property p_oe; $rose(modeValid) |-> ##[0:1] reportLedsOe == (mode == ModeSelfCheck); endproperty
  a_oe: assert property (p_oe) else $error("led drive wrong");
  property p_io; selfCheckPassDone && selfCheckFaults.ioFault && mode == ModeSelfCheck
    && !faultSeen_q |=> reportLeds == REPORT_IO_FAULT; endproperty
  a_io: assert property (p_io) else $error("io code wrong");
  property p_again; selfCheckPassDone && selfCheckFaults == 4'h0 && mode == ModeSelfCheck
    && !faultSeen_q |=> selfCheckRestart; endproperty
  a_again: assert property (p_again) else $error("no restart");
  property p_prog; progAllowed == (mode == ModeBootstrap && progAddr >= USER_MEM_START
    && progAddr <= USER_MEM_END); endproperty
  a_prog: assert property (p_prog) else $error("write window wrong");
endmodule
bind rms_mode_select rms_mode_select_asserts #(.PROGRAMMABLE(PROGRAMMABLE),
  .WDOG_TIMEOUT(WDOG_TIMEOUT), .STEP_CYCLES(STEP_CYCLES)) chk (.clk(clk), .rst(rst),
  .irqElevated(irqElevated), .modeStrapPin(modeStrapPin), .progAddr(progAddr),
  .selfCheckPassDone(selfCheckPassDone), .selfCheckFaults(selfCheckFaults),
  .chipReset(chipReset), .mode(mode), .modeValid(modeValid), .startVector(startVector),
  .selfCheckRestart(selfCheckRestart), .progAllowed(progAllowed),
  .reportLeds(reportLeds), .reportLedsOe(reportLedsOe));
`default_nettype wire

// *** rms_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module rms_board (
  // clock in, reset-time pins out
  input wire logic clk,
  output logic rst,
  output logic irqElevated,
  output logic modeStrapPin
);
  initial begin
    rst = 1'b1;
    irqElevated = 1'b0;
    modeStrapPin = 1'b0;
  end
  // straps under reset, release, then reuse the pins as ordinary inputs
  task automatic pulseReset(input logic irq, input logic strap, input int holdCycles);
    @(posedge clk);
    #1 rst = 1'b1;
    irqElevated = irq;
    modeStrapPin = strap;
    repeat (holdCycles) @(posedge clk);
    #1 rst = 1'b0;
    // only the minimum hold after release, then the pins move on
    repeat (2) @(posedge clk);
    #1 irqElevated = ~irq;
    modeStrapPin = ~strap;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** reset_mode_select_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module reset_mode_select_tb_top;
  import rms_pkg::*;
  logic clk = 1'b0;
  logic rst, irqElevated, modeStrapPin, wdogService = 1'b0, selfCheckPassDone = 1'b0;
  logic svcOn = 1'b1, chipReset, modeValid, selfCheckRestart, progAllowed, reportLedsOe;
  logic [15:0] progAddr = 16'h0000, startVector;
  rms_faults_t selfCheckFaults = 4'h0;
  rms_mode_t mode;
  rms_leds_t reportLeds;
  int badCount = 0, numChecks = 0;
  always #2.5 clk = ~clk;
  rms_board board (.clk(clk), .rst(rst), .irqElevated(irqElevated), .modeStrapPin(modeStrapPin));
  // short watchdog count keeps the starvation test brief
  rms_mode_select #(.PROGRAMMABLE(1'b1), .WDOG_TIMEOUT(64), .STEP_CYCLES(16)) dut (.clk(clk),
    .rst(rst), .irqElevated(irqElevated), .modeStrapPin(modeStrapPin), .wdogService(wdogService),
    .chipReset(chipReset), .mode(mode), .modeValid(modeValid), .startVector(startVector),
    .selfCheckPassDone(selfCheckPassDone), .selfCheckFaults(selfCheckFaults),
    .selfCheckRestart(selfCheckRestart), .progAddr(progAddr), .progAllowed(progAllowed),
    .reportLeds(reportLeds), .reportLedsOe(reportLedsOe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // periodic service, well inside the shortened count
  initial forever begin
    repeat (20) @(posedge clk);
    #1 wdogService = svcOn;
    @(posedge clk);
    #1 wdogService = 1'b0;
  end
  task automatic doPass(input logic [3:0] f);
    @(posedge clk);
    #1 selfCheckFaults = f;
    selfCheckPassDone = 1'b1;
    @(posedge clk);
    #1 selfCheckPassDone = 1'b0;
  endtask
  task automatic testUser;
    board.pulseReset(1'b0, 1'b1, 10);
    check(modeValid, 1'b1);
    check(mode, ModeUser);
    check(reportLedsOe, 1'b0);
    $display("test user done");
  endtask
  task automatic testBoot;
    logic [15:0] addrs [4] = '{16'h1FFF, 16'h2000, 16'h3EFF, 16'h3F00};
    board.pulseReset(1'b1, 1'b1, 4);
    check(mode, ModeBootstrap);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 progAddr = addrs[i];
      #1 check(progAllowed, i == 1 || i == 2);
    end
    $display("test bootstrap done");
  endtask
  task automatic testSelf;
    rms_leds_t first;
    int flips = 0;
    board.pulseReset(1'b1, 1'b0, 4);
    check(mode, ModeSelfCheck);
    check(startVector, SELF_CHECK_START);
    check(reportLedsOe, 1'b1);
    first = reportLeds;
    repeat (3) begin
      doPass(4'h0);
      check(selfCheckRestart, 1'b1);
      repeat (20) @(posedge clk);
      if (reportLeds !== first) flips++;
    end
    check(flips > 0, 1'b1);
    doPass(4'h8);
    check(reportLeds, REPORT_IO_FAULT);
    doPass(4'h0);
    check(selfCheckRestart, 1'b0);
    check(reportLeds, REPORT_IO_FAULT);
    $display("test self-check done");
  endtask
  task automatic testFaults;
    logic [2:0] codes [4] = '{REPORT_IO_FAULT, REPORT_RAM_FAULT, REPORT_ROM_FAULT, REPORT_IRQ_FAULT};
    // the irq bit rides along to show that the higher unit wins
    for (int i = 0; i < 4; i++) begin
      board.pulseReset(1'b1, 1'b0, 4);
      doPass((4'h8 >> i) | 4'h1);
      check(reportLeds, codes[i]);
    end
    $display("test fault codes done");
  endtask
  task automatic testWdog;
    int n = 0;
    int hi = 0;
    svcOn = 1'b0;
    while (chipReset !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    while (chipReset === 1'b1 && hi < 10) begin
      @(posedge clk);
      #1 hi++;
    end
    check(n > 40 && n < 70, 1'b1);
    check(hi[15:0], 16'(WDOG_PULSE_CYCLES));
    svcOn = 1'b1;
    $display("test watchdog done");
  endtask
  initial begin
    testUser;
    testBoot;
    testSelf;
    testFaults;
    testWdog;
    giveVerdict;
  end
  // hang guard, about forty times the expected run
  initial begin
    #50000;
    badCount++;
    giveVerdict;
  end
endmodule
`default_nettype wire
